// [core/wwdt_pkg.sv]
// Purpose: Constants shared by the windowed watchdog design.
// Assumes: AXI4-Lite with 32-bit data, byte offsets as printed.
// Notes:   Figures of the block live here, except the 12'hfff count reset and the 4'hc unmapped offset in wwdt_top.
package wwdt_pkg;
   // Register byte offsets.
   localparam logic [3:0]  RESTART_CONTROL_OFS = 4'h0;
   localparam logic [3:0]  MODE_CONFIG_OFS     = 4'h4;
   localparam logic [3:0]  FAULT_STATUS_OFS    = 4'h8;
   // Restart control fields.
   localparam logic [7:0]  RESTART_KEY         = 8'ha5;
   localparam int          KEY_LSB             = 24;
   localparam int          RESTART_REQUEST_BIT = 0;
   // Mode configuration fields and reset value.
   localparam logic [31:0] MODE_RESET          = 32'h3fff2fff;
   localparam logic [31:0] MODE_WRITE_MASK     = 32'h3fffffff;
   localparam int          LOAD_LSB            = 0;
   localparam int          FAULT_IRQ_EN_BIT    = 12;
   localparam int          FAULT_RESET_EN_BIT  = 13;
   localparam int          PROC_ONLY_BIT       = 14;
   localparam int          DISABLE_BIT         = 15;
   localparam int          DELTA_LSB           = 16;
   localparam int          HALT_DEBUG_BIT      = 28;
   localparam int          HALT_IDLE_BIT       = 29;
   // Status fields.
   localparam int          UNDERFLOW_BIT       = 0;
   localparam int          WINDOW_ERROR_BIT    = 1;
   // Slow clock and prescaler.
   localparam int          SLOW_DIV            = 128;
   localparam logic [6:0]  SLOW_DIV_LAST       = 7'h7f;
   // AXI responses.
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;
endpackage

// [core/wwdt_prescaler.sv]
// Purpose: Divide-by-128 of the slow clock enable.
// Assumes: Slow clock arrives as a one-cycle enable on CLK.
// Notes:   A restart inside the window clears the divider so the next period is whole.
`timescale 1ns/1ps
module wwdt_prescaler (
   // Clock and reset.
   input  wire logic CLK,
   input  wire logic RSTN,
   // Control.
   input  wire logic slow_tick,
   input  wire logic clear,
   // Output.
   output logic      div_tick
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic       tick_d;

   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (clear) begin
         cnt_d = 7'h00;
      end else if (slow_tick) begin
         cnt_d  = cnt_q + 7'h01;
         tick_d = (cnt_q == wwdt_pkg::SLOW_DIV_LAST);
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign div_tick = tick_d;
endmodule

// [core/wwdt_top.sv]
// Purpose: Windowed watchdog timer with an AXI4-Lite register slave.
// Assumes: All inputs synchronous to CLK; SLOW_TICK pulses once per slow clock.
// Notes:   Fault outputs are levels held until the status is read or reset.
`timescale 1ns/1ps
module wwdt_top (
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // AXI4-Lite write address.
   input  wire logic [31:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   // AXI4-Lite write data.
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   // AXI4-Lite write response.
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read address.
   input  wire logic [31:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   // AXI4-Lite read data.
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // System state.
   input  wire logic        SLOW_TICK,
   input  wire logic        DEBUG_STATE,
   input  wire logic        IDLE_MODE,
   // Fault outputs.
   output logic             FAULT_IRQ,
   output logic             FAULT_RESET_REQ,
   output logic             PROC_ONLY_RESET
);
   // Write channel state.
   logic        aw_held_q;
   logic        aw_held_d;
   logic        w_held_q;
   logic        w_held_d;
   logic [3:0]  awaddr_q;
   logic [3:0]  awaddr_d;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic        bvalid_q;
   logic        bvalid_d;
   logic [1:0]  bresp_q;
   logic [1:0]  bresp_d;
   // Ready outputs are flops of their own so that no port is driven by a gate.
   logic        awready_q;
   logic        wready_q;
   logic        arready_q;
   // Read channel state.
   logic        rvalid_q;
   logic        rvalid_d;
   logic [1:0]  rresp_q;
   logic [1:0]  rresp_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   // Watchdog state.
   logic [31:0] mode_q;
   logic [31:0] mode_d;
   logic        mode_locked_q;
   logic        mode_locked_d;
   logic [11:0] count_q;
   logic [11:0] count_d;
   logic        unf_q;
   logic        unf_d;
   logic        err_q;
   logic        err_d;
   logic        irq_q;
   logic        irq_d;
   logic        rst_q;
   logic        rst_d;
   logic        proc_q;
   logic        proc_d;
   // Decoded events.
   logic        wr_fire;
   logic        rd_fire;
   logic        status_read;
   logic        restart_ok;
   logic        restart_bad;
   logic        mode_wr;
   logic        halted;
   logic        underflow;
   logic        pre_clear;
   logic        div_tick;
   logic        bad_wr_addr;

   function automatic logic addr_known(input logic [31:0] a);
      addr_known = (a[31:4] == 28'h0000000) && (a[1:0] == 2'b00) &&
                   (a[3:0] != 4'hc);
   endfunction

   function automatic logic [11:0] field12(input logic [31:0] v, input int lsb);
      field12 = 12'(v >> lsb);
   endfunction

   // Read decode used by the data path and by the status clear alike.
   function automatic logic reg_hit(input logic [31:0] a, input logic [3:0] ofs);
      reg_hit = addr_known(a) && (a[3:0] == ofs);
   endfunction

   // Bits 31:30 are not implemented, so they always read back as zero.
   function automatic logic [31:0] mode_masked(input logic [31:0] v);
      mode_masked = v & wwdt_pkg::MODE_WRITE_MASK;
   endfunction

   // A write completes when both halves are held and no response is pending.
   assign wr_fire     = aw_held_q && w_held_q && !bvalid_q;
   assign bad_wr_addr = !addr_known({28'h0000000, awaddr_q}) ||
                        (awaddr_q == wwdt_pkg::FAULT_STATUS_OFS);
   assign rd_fire     = ARVALID && !rvalid_q;
   assign status_read = rd_fire && reg_hit(ARADDR, wwdt_pkg::FAULT_STATUS_OFS);
   // Only a full-word write with the key is a restart command.
   assign restart_ok  = wr_fire && (awaddr_q == wwdt_pkg::RESTART_CONTROL_OFS) &&
                        (wdata_q[31:wwdt_pkg::KEY_LSB] == wwdt_pkg::RESTART_KEY) &&
                        wdata_q[wwdt_pkg::RESTART_REQUEST_BIT];
   assign restart_bad = restart_ok &&
                        (count_q > field12(mode_q, wwdt_pkg::DELTA_LSB));
   assign mode_wr     = wr_fire && (awaddr_q == wwdt_pkg::MODE_CONFIG_OFS) &&
                        !mode_locked_q;
   assign halted      = mode_q[wwdt_pkg::DISABLE_BIT] ||
                        (mode_q[wwdt_pkg::HALT_DEBUG_BIT] && DEBUG_STATE) ||
                        (mode_q[wwdt_pkg::HALT_IDLE_BIT] && IDLE_MODE);
   assign underflow   = div_tick && !halted && (count_q == 12'h000);
   assign pre_clear   = (restart_ok && !restart_bad) || mode_wr;

   wwdt_prescaler u_prescaler (
      .CLK       (CLK),
      .RSTN      (RSTN),
      .slow_tick (SLOW_TICK),
      .clear     (pre_clear),
      .div_tick  (div_tick)
   );

   // Bus slave next state.
   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (AWVALID && !aw_held_q) begin
         aw_held_d = 1'b1;
         awaddr_d  = AWADDR[31:4] == 28'h0000000 ? AWADDR[3:0] : 4'hc;
      end
      if (WVALID && !w_held_q) begin
         w_held_d = 1'b1;
         // Partial strobes clear the key byte, so they never restart.
         wdata_d  = (WSTRB == 4'hf) ? WDATA : 32'h00000000;
      end
      if (wr_fire) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = bad_wr_addr ? wwdt_pkg::RESP_SLVERR : wwdt_pkg::RESP_OKAY;
      end else if (bvalid_q && BREADY) begin
         bvalid_d = 1'b0;
      end
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d  = wwdt_pkg::RESP_OKAY;
         rdata_d  = 32'h00000000;
         if (!addr_known(ARADDR)) begin
            rresp_d = wwdt_pkg::RESP_SLVERR;
         end else if (reg_hit(ARADDR, wwdt_pkg::MODE_CONFIG_OFS)) begin
            rdata_d = mode_q;
         end else if (reg_hit(ARADDR, wwdt_pkg::FAULT_STATUS_OFS)) begin
            rdata_d = {30'h0, err_q, unf_q};
         end
      end else if (rvalid_q && RREADY) begin
         rvalid_d = 1'b0;
      end
   end

   // Watchdog next state.
   always_comb begin
      mode_d        = mode_q;
      mode_locked_d = mode_locked_q;
      count_d       = count_q;
      unf_d         = unf_q;
      err_d         = err_q;
      if (mode_wr) begin
         mode_d        = mode_masked(wdata_q);
         mode_locked_d = 1'b1;
         count_d       = field12(wdata_q, wwdt_pkg::LOAD_LSB);
      end else if (restart_ok && !restart_bad) begin
         count_d = field12(mode_q, wwdt_pkg::LOAD_LSB);
      end else if (div_tick && !halted) begin
         count_d = count_q - 12'h001;
      end
      // Clearing by a read loses to a fault in the same cycle.
      if (status_read) begin
         unf_d = 1'b0;
         err_d = 1'b0;
      end
      if (underflow) begin
         unf_d = 1'b1;
      end
      if (restart_bad) begin
         err_d = 1'b1;
      end
      irq_d  = mode_d[wwdt_pkg::FAULT_IRQ_EN_BIT] && (unf_d || err_d);
      rst_d  = mode_d[wwdt_pkg::FAULT_RESET_EN_BIT] && (unf_d || err_d);
      proc_d = rst_d && mode_d[wwdt_pkg::PROC_ONLY_BIT];
   end

   // Bus slave registers.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 32'h00000000;
         bvalid_q      <= 1'b0;
         bresp_q       <= 2'h0;
         awready_q     <= 1'b1;
         wready_q      <= 1'b1;
         arready_q     <= 1'b1;
         rvalid_q      <= 1'b0;
         rresp_q       <= 2'h0;
         rdata_q       <= 32'h00000000;
      end else begin
         aw_held_q     <= aw_held_d;
         w_held_q      <= w_held_d;
         awaddr_q      <= awaddr_d;
         wdata_q       <= wdata_d;
         bvalid_q      <= bvalid_d;
         bresp_q       <= bresp_d;
         awready_q     <= !aw_held_d;
         wready_q      <= !w_held_d;
         arready_q     <= !rvalid_d;
         rvalid_q      <= rvalid_d;
         rresp_q       <= rresp_d;
         rdata_q       <= rdata_d;
      end
   end

   // Watchdog registers.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_q        <= wwdt_pkg::MODE_RESET;
         mode_locked_q <= 1'b0;
         count_q       <= 12'hfff;
         unf_q         <= 1'b0;
         err_q         <= 1'b0;
         irq_q         <= 1'b0;
         rst_q         <= 1'b0;
         proc_q        <= 1'b0;
      end else begin
         mode_q        <= mode_d;
         mode_locked_q <= mode_locked_d;
         count_q       <= count_d;
         unf_q         <= unf_d;
         err_q         <= err_d;
         irq_q         <= irq_d;
         rst_q         <= rst_d;
         proc_q        <= proc_d;
      end
   end

   assign AWREADY         = awready_q;
   assign WREADY          = wready_q;
   assign BVALID          = bvalid_q;
   assign BRESP           = bresp_q;
   assign ARREADY         = arready_q;
   assign RVALID          = rvalid_q;
   assign RRESP           = rresp_q;
   assign RDATA           = rdata_q;
   assign FAULT_IRQ       = irq_q;
   assign FAULT_RESET_REQ = rst_q;
   assign PROC_ONLY_RESET = proc_q;
endmodule

// [testbench/wwdt_chk.sv]
// Purpose: Port-level checks of the windowed watchdog.
// Assumes: One clock domain, reset active low.
// Notes:   Fault outputs are judged one edge after their cause.
`timescale 1ns/1ps
module wwdt_chk (
   // Clock and reset.
   input wire logic        CLK,
   input wire logic        RSTN,
   // Register bus.
   input wire logic        AWREADY,
   input wire logic        AWVALID,
   input wire logic        WREADY,
   input wire logic        WVALID,
   input wire logic        BVALID,
   input wire logic [31:0] ARADDR,
   input wire logic        ARVALID,
   input wire logic        ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0]  RRESP,
   input wire logic        RVALID,
   // System and faults.
   input wire logic        SLOW_TICK,
   input wire logic        FAULT_IRQ,
   input wire logic        FAULT_RESET_REQ,
   input wire logic        PROC_ONLY_RESET
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   wire ar_take = ARVALID && ARREADY;
   proc_scope_a: assert property (PROC_ONLY_RESET |-> FAULT_RESET_REQ)
      else $error("processor-only reset without reset request");
   irq_cause_a: assert property ($rose(FAULT_IRQ) |-> $past(SLOW_TICK) || !$past(AWREADY))
      else $error("interrupt rose without a fault cause");
   rst_cause_a: assert property ($rose(FAULT_RESET_REQ) |-> $past(SLOW_TICK) || !$past(AWREADY))
      else $error("reset request rose without a fault cause");
   status_clear_a: assert property (ar_take && ARADDR == 32'h8 && !SLOW_TICK && AWREADY
      |=> !FAULT_IRQ && !FAULT_RESET_REQ) else $error("status read left faults up");
   status_bits_a: assert property (ar_take && ARADDR == 32'h8 |=> RDATA[31:2] == 30'h0)
      else $error("status read shows unused bits");
   mode_top_a: assert property (ar_take && ARADDR == 32'h4 |=> RDATA[31:30] == 2'h0)
      else $error("mode read shows unused bits");
   unmapped_rd_a: assert property (ar_take && ARADDR == 32'hc
      |=> RRESP == wwdt_pkg::RESP_SLVERR && RDATA == 32'h0) else $error("unmapped read answered");
   rd_answer_a: assert property (ar_take |=> RVALID) else $error("read answer late");
   wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
      else $error("write answer late");
   cover property ($rose(FAULT_IRQ));
   cover property (ar_take && ARADDR == 32'h8 && FAULT_IRQ);
   cover property (ar_take && ARADDR == 32'hc);
endmodule
bind wwdt_top wwdt_chk u_chk (.CLK, .RSTN, .AWREADY, .AWVALID, .WREADY, .WVALID, .BVALID,
   .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .SLOW_TICK, .FAULT_IRQ,
   .FAULT_RESET_REQ, .PROC_ONLY_RESET);

// [testbench/wwdt_rstc_model.sv]
// Purpose: Reset and interrupt controller seen from the watchdog.
// Assumes: Fault outputs are levels on the same clock.
// Notes:   It only counts requests; the bench decides when to reset.
`timescale 1ns/1ps
module wwdt_rstc_model (
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       RSTN,
   // Watchdog faults.
   input  wire logic       fault_irq,
   input  wire logic       fault_req,
   input  wire logic       proc_only,
   // Observed requests.
   output logic      [7:0] proc_cnt,
   output logic      [7:0] full_cnt,
   output logic      [7:0] irq_cnt
);
   logic req_q;
   logic irq_q;
   // A level request is counted once, on its rising edge.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         {req_q, irq_q, proc_cnt, full_cnt, irq_cnt} <= '0;
      end else begin
         req_q <= fault_req;
         irq_q <= fault_irq;
         if (fault_req && !req_q && proc_only) proc_cnt <= proc_cnt + 8'h01;
         if (fault_req && !req_q && !proc_only) full_cnt <= full_cnt + 8'h01;
         if (fault_irq && !irq_q) irq_cnt <= irq_cnt + 8'h01;
      end
   end
endmodule

// [testbench/windowed_watchdog_timer_tb.sv]
// Purpose: Self-checking bench for the windowed watchdog.
// Assumes: Slow clock given as one-cycle ticks on the bus clock.
// Notes:   Reads and responses are queued by the driver, checked by a monitor.
`timescale 1ns/1ps
module windowed_watchdog_timer_tb;
   localparam logic [31:0] ctrl_a = 32'(wwdt_pkg::RESTART_CONTROL_OFS);
   localparam logic [31:0] mode_a = 32'(wwdt_pkg::MODE_CONFIG_OFS);
   localparam logic [31:0] stat_a = 32'(wwdt_pkg::FAULT_STATUS_OFS);
   localparam logic [1:0]  rsp_ok = wwdt_pkg::RESP_OKAY;
   localparam logic [1:0]  rsp_err = wwdt_pkg::RESP_SLVERR;
   logic        clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, slow = 0, dbg = 0, idle = 0;
   logic        idle_force = 0, idle_lvl = 0;
   logic [3:0]  wstrb = 4'hf;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic        awready, wready, bvalid, arready, rvalid, irq, req, proc;
   logic [1:0]  bresp, rresp;
   logic [7:0]  proc_cnt, full_cnt, irq_cnt;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   integer      seed = 32'h4875;
   int          error_cnt = 0, tests_run = 0, cyc = 0;
   always #2.5 clk = ~clk;
   wwdt_top DUT (.CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .SLOW_TICK(slow), .DEBUG_STATE(dbg), .IDLE_MODE(idle), .FAULT_IRQ(irq),
      .FAULT_RESET_REQ(req), .PROC_ONLY_RESET(proc));
   wwdt_rstc_model partner (.CLK(clk), .RSTN(rstn), .fault_irq(irq), .fault_req(req),
      .proc_only(proc), .proc_cnt(proc_cnt), .full_cnt(full_cnt), .irq_cnt(irq_cnt));
   task automatic chk(input string nm, input logic [33:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
      @(posedge clk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
      @(posedge clk);
      rq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   // Idle mode toggles at random; with its halt bit clear it must not stop counting.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         slow <= 1'b1;
         idle <= idle_force ? idle_lvl : 1'($random(seed));
         @(posedge clk);
         slow <= 1'b0;
      end
   endtask
   // Reset is pulled mid-run while the bus is quiet, then released on an edge.
   task automatic pulse_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
      if (cyc == 12000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd(mode_a, wwdt_pkg::MODE_RESET, rsp_ok);
      rd(stat_a, 32'h0, rsp_ok);
      rd(ctrl_a, 32'h0, rsp_ok);
      rd(32'hc, 32'h0, rsp_err);
      wr(stat_a, 32'h3, rsp_err);
      // Load 5, window 3, debug halt, processor-only reset, both fault outputs on.
      wr(mode_a, 32'h10037005, rsp_ok);
      wr(mode_a, 32'h00008000, rsp_ok);
      rd(mode_a, 32'h10037005, rsp_ok);
      wr(ctrl_a, 32'h5a000001, rsp_ok);
      wr(ctrl_a, 32'ha5000000, rsp_ok);
      // A partial-strobe write must never count as a keyed restart.
      wstrb <= 4'h7;
      wr(ctrl_a, 32'ha5000001, rsp_ok);
      wstrb <= 4'hf;
      rd(stat_a, 32'h0, rsp_ok);
      wr(ctrl_a, 32'ha5000001, rsp_ok);
      #1 chk("faults", {irq, req, proc}, 3'h7);
      rd(stat_a, 32'h2, rsp_ok);
      #1 chk("faults", {irq, req, proc}, 3'h0);
      rd(stat_a, 32'h0, rsp_ok);
      // A running counter would underflow after 768 ticks, so 800 halted ticks prove the stop.
      dbg <= 1'b1;
      ticks(800);
      rd(stat_a, 32'h0, rsp_ok);
      dbg <= 1'b0;
      ticks(256);
      wr(ctrl_a, 32'ha5000001, rsp_ok);
      ticks(767);
      rd(stat_a, 32'h0, rsp_ok);
      ticks(1);
      rd(stat_a, 32'h1, rsp_ok);
      chk("requests", {2'h0, proc_cnt, full_cnt, irq_cnt}, {2'h0, 24'h020002});
      // After a mid-run reset: load 2, window 0, idle halt, full reset, no interrupt.
      pulse_reset();
      rd(mode_a, wwdt_pkg::MODE_RESET, rsp_ok);
      wr(mode_a, 32'h20002002, rsp_ok);
      idle_force <= 1'b1;
      idle_lvl <= 1'b1;
      ticks(384);
      rd(stat_a, 32'h0, rsp_ok);
      idle_lvl <= 1'b0;
      ticks(384);
      #1 chk("faults", {irq, req, proc}, 3'h2);
      @(posedge clk);
      #1 chk("requests", {2'h0, proc_cnt, full_cnt, irq_cnt}, {2'h0, 24'h000100});
      // A reset with the fault raised must drop it and clear the flags.
      pulse_reset();
      #1 chk("faults", {irq, req, proc}, 3'h0);
      rd(stat_a, 32'h0, rsp_ok);
      // Disabled timer: no underflow, yet an early restart still faults.
      wr(mode_a, 32'h00009001, rsp_ok);
      ticks(384);
      rd(stat_a, 32'h0, rsp_ok);
      wr(ctrl_a, 32'ha5000001, rsp_ok);
      #1 chk("faults", {irq, req, proc}, 3'h4);
      rd(stat_a, 32'h2, rsp_ok);
      complete_run();
   end
endmodule
